// >>> core/bws_top.sv
// Purpose: Basic timer acting as watchdog and oscillation stabilization timer.
// Assumes: Register port is synchronous; a write takes effect the next cycle.
// Notes: A watchdog reset re-enters stabilization just like a system reset.
// Function
// RL1: Reset clears control; watchdog on, divide 4096.
// RL2: Upper nibble 1010 alone disables watchdog.
// RL3: Bits 3:2 select divide 4096/1024/128/16384.
// RL4: Writing bit 1 clears counter, self-clears.
// RL5: Writing bit 0 clears both prescalers, self-clears.
// RL6: Enabled watchdog overflow resets the chip.
// RL7: Overflow is carry out of counter bit 7.
// RL8: Software clears counter regularly to avoid reset.
// RL9: After reset counter clock is CPU/4096.
// RL10: Stop mode wake restarts oscillator and stabilization.
// RL11: Stabilize at /4096 after reset, else preset.
// RL12: Bit 3 overflow ends stabilization, releases CPU.
// RL13: Control register read/write at D3h.
// RL14: Counter read-only at FDh, readable anytime.
// RL15: Disabled watchdog overflow wraps silently.
// RL16: Watchdog reset pulses and reinitializes block.
`timescale 1ns/1ps
`default_nettype none
module bws_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Power management
    input wire logic stop_req,
    input wire logic ext_wake,
    // System outputs
    output logic cpu_clk_en,
    output logic stab_done,
    output logic wdt_reset_req,
    output logic gt_presc_clear
);
    // =====================================================================
    // State
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wdt_rst_q;
    logic cpu_en_q;
    logic done_q;
    logic gtclr_q;
    bws_pkg::bws_state_t state_q;
    bws_pkg::bws_state_t state_d;

    // =====================================================================
    // Decode
    logic blk_reset;
    logic wr_ctrl;
    logic cnt_clr;
    logic div_clr;
    logic wdt_on;
    logic run;
    logic tick;
    logic ovf;
    logic stab_ovf;
    logic wdt_fire;

    // The watchdog pulse reinitializes everything but the read data one cycle after it fires.
    assign blk_reset = reset || wdt_rst_q; // RL16
    assign wr_ctrl = reg_wr && (reg_addr == bws_pkg::CTRL_ADDR); // RL13
    assign cnt_clr = wr_ctrl && reg_wdata[bws_pkg::CNT_CLR_BIT]; // RL4
    assign div_clr = wr_ctrl && reg_wdata[bws_pkg::DIV_CLR_BIT]; // RL5
    assign wdt_on = (ctrl_q[bws_pkg::EN_MSB:bws_pkg::EN_LSB] != bws_pkg::DISABLE_CODE); // RL2
    assign run = (state_q != bws_pkg::ST_STOP);
    assign ovf = tick && (cnt_q == bws_pkg::CNT_MAX) && !cnt_clr; // RL7
    assign stab_ovf = tick && (cnt_q[bws_pkg::STAB_BIT:0] == bws_pkg::STAB_LOW_MAX)
        && (state_q == bws_pkg::ST_STAB); // RL12
    assign wdt_fire = ovf && wdt_on && (state_q == bws_pkg::ST_RUN); // RL6

    bws_prescaler u_presc (
        .clk(clk),
        .reset(blk_reset),
        .run(run),
        .clear(div_clr),
        .sel(ctrl_q[bws_pkg::SEL_MSB:bws_pkg::SEL_LSB]), // RL11
        .tick(tick)
    );

    // Clear bits are never stored, so they always read back as zero.
    assign ctrl_d = wr_ctrl ? {reg_wdata[7:2], 2'b00} : ctrl_q; // RL13

    // A clear in the same cycle as a tick wins, so a timely clear never loses.
    assign cnt_d = (cnt_clr || (state_q == bws_pkg::ST_STOP && state_d == bws_pkg::ST_STAB))
        ? 8'h00 : (tick ? cnt_q + 8'h01 : cnt_q); // RL4 RL15

    assign rdata_d = !reg_rd ? rdata_q :
        (reg_addr == bws_pkg::CTRL_ADDR) ? ctrl_q :
        (reg_addr == bws_pkg::CNT_ADDR) ? cnt_q : bws_pkg::UNMAPPED_READ; // RL14

    always_comb begin
        state_d = state_q;
        case (state_q)
            bws_pkg::ST_RUN: begin
                if (stop_req) begin
                    state_d = bws_pkg::ST_STOP;
                end
            end
            bws_pkg::ST_STOP: begin
                if (ext_wake) begin
                    state_d = bws_pkg::ST_STAB; // RL10
                end
            end
            bws_pkg::ST_STAB: begin
                if (stab_ovf) begin
                    state_d = bws_pkg::ST_RUN; // RL12
                end
            end
            default: state_d = bws_pkg::ST_STAB;
        endcase
    end

    // =====================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (blk_reset) begin
            ctrl_q <= bws_pkg::CTRL_RESET; // RL1 RL9
            cnt_q <= 8'h00;
            state_q <= bws_pkg::ST_STAB; // RL10 RL11
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wdt_rst_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            wdt_rst_q <= wdt_fire; // RL6 RL16
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (blk_reset) begin
            cpu_en_q <= 1'b0;
            done_q <= 1'b0;
            gtclr_q <= 1'b0;
        end else begin
            cpu_en_q <= (state_d == bws_pkg::ST_RUN); // RL12
            done_q <= stab_ovf;
            gtclr_q <= div_clr; // RL5
        end
    end

    assign reg_rdata = rdata_q;
    assign cpu_clk_en = cpu_en_q;
    assign stab_done = done_q;
    assign wdt_reset_req = wdt_rst_q;
    assign gt_presc_clear = gtclr_q;

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    ctrl_reset_a: assert property ($rose(wdt_rst_q) |=> ctrl_q == bws_pkg::CTRL_RESET) // RL1
        else $error("control not cleared by watchdog reset");
    disable_code_a: assert property (ovf && !wdt_on |=> !wdt_rst_q) // RL2
        else $error("disabled watchdog still fired");
    clr_bits_a: assert property (ctrl_q[1:0] == 2'b00) // RL4
        else $error("self-clearing bits stored");
    cnt_clear_a: assert property (cnt_clr && !wdt_rst_q |=> cnt_q == 8'h00) // RL4
        else $error("counter clear write ignored");
    gt_clear_a: assert property (div_clr && !wdt_rst_q |=> gt_presc_clear) // RL5
        else $error("general prescaler clear pulse missing");
    wdt_fire_a: assert property (wdt_fire |=> wdt_reset_req ##1 (cnt_q == 8'h00)) // RL6
        else $error("overflow did not reset");
    silent_wrap_a: assert property (ovf && !wdt_on && state_q == bws_pkg::ST_RUN
        |=> cnt_q == 8'h00 && !wdt_reset_req) // RL15
        else $error("disabled overflow misbehaved");
    stab_end_a: assert property (stab_ovf && !cnt_clr |=> stab_done && cpu_clk_en
        && cnt_q[bws_pkg::STAB_BIT:0] == 4'h0) // RL12
        else $error("stabilization end wrong");
    stab_hold_a: assert property (state_d != bws_pkg::ST_RUN |=> !cpu_clk_en) // RL10
        else $error("cpu clock released early");
    cnt_read_a: assert property (reg_rd && reg_addr == bws_pkg::CNT_ADDR
        |=> reg_rdata == $past(cnt_q)) // RL14
        else $error("counter read wrong");

    wdt_reset_c: cover property (wdt_fire);
    wake_c: cover property (state_q == bws_pkg::ST_STOP ##1 state_q == bws_pkg::ST_STAB);
    stab_done_c: cover property (stab_done);
    disabled_c: cover property (ovf && !wdt_on);
    sel_slow_c: cover property (tick && ctrl_q[bws_pkg::SEL_MSB:bws_pkg::SEL_LSB]
        == bws_pkg::SEL_16384);

    // =====================================================================
    // Check helpers
    // The last write data is kept here so the control checks need no copy of the decode.
    // It has no reset because it is only read one cycle after a write was seen.
    logic [7:0] wdata_seen_q;
    always_ff @(posedge clk) begin
        wdata_seen_q <= reg_wdata;
    end

    // =====================================================================
    // Register port checks
    // Software only sees this block through the port, so every read path is pinned.
    ctrl_write_a: assert property (wr_ctrl && !blk_reset // RL13
        |=> ctrl_q[7:2] == wdata_seen_q[7:2])
        else $error("control write did not land");
    ctrl_hold_a: assert property (!wr_ctrl && !blk_reset // RL13
        |=> $stable(ctrl_q))
        else $error("control changed without a write");
    ctrl_read_a: assert property (reg_rd && reg_addr == bws_pkg::CTRL_ADDR // RL13
        |=> reg_rdata == $past(ctrl_q))
        else $error("control read wrong");
    unmapped_read_a: assert property (reg_rd && reg_addr != bws_pkg::CTRL_ADDR // RL13
        && reg_addr != bws_pkg::CNT_ADDR |=> reg_rdata == bws_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd // RL14
        |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    cnt_readonly_a: assert property (reg_wr && reg_addr == bws_pkg::CNT_ADDR && !tick // RL14
        && !blk_reset && state_q == bws_pkg::ST_RUN |=> $stable(cnt_q))
        else $error("counter took a bus write");

    // =====================================================================
    // Counter and prescaler checks
    // The fastest rate is one tick in 128 clocks, so ticks never touch.
    tick_gap_a: assert property (tick // RL3
        |=> !tick)
        else $error("prescaler ticks back to back");
    div_clr_tick_a: assert property (div_clr // RL5
        |-> !tick)
        else $error("tick during prescaler clear");
    gt_clear_src_a: assert property (gt_presc_clear // RL5
        |-> $past(div_clr))
        else $error("stray general prescaler clear");
    cnt_step_a: assert property (tick && !cnt_clr && !blk_reset // RL7
        && state_q != bws_pkg::ST_STOP |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not advance on tick");
    cnt_idle_a: assert property (!tick && !cnt_clr && !blk_reset // RL7
        && state_q == bws_pkg::ST_RUN |=> $stable(cnt_q))
        else $error("counter moved without a tick");
    clr_wins_a: assert property (cnt_clr && tick && cnt_q == bws_pkg::CNT_MAX // RL4
        |=> !wdt_reset_req)
        else $error("timely clear lost to overflow");

    // =====================================================================
    // Watchdog checks
    // A reset request must come only from an enabled overflow while running.
    wdt_pulse_a: assert property (wdt_reset_req // RL16
        |=> !wdt_reset_req)
        else $error("watchdog request longer than one cycle");
    wdt_cause_a: assert property (wdt_reset_req // RL6
        |-> $past(ovf) && $past(wdt_on))
        else $error("watchdog request without enabled overflow");
    wdt_run_only_a: assert property (state_q != bws_pkg::ST_RUN // RL6
        |=> !wdt_reset_req)
        else $error("watchdog request outside run");
    wdt_reinit_a: assert property (wdt_reset_req // RL16
        |=> !cpu_clk_en && !stab_done && state_q == bws_pkg::ST_STAB)
        else $error("watchdog reset did not restart stabilization");

    // =====================================================================
    // Stop and stabilization checks
    // The oscillator is treated as stopped, so nothing may count in stop.
    stop_freeze_a: assert property (state_q == bws_pkg::ST_STOP && !ext_wake // RL10
        && !cnt_clr && !blk_reset |=> $stable(cnt_q))
        else $error("counter moved in stop");
    stop_no_tick_a: assert property (state_q == bws_pkg::ST_STOP // RL10
        |-> !tick)
        else $error("prescaler ticked in stop");
    stop_enter_a: assert property (state_q == bws_pkg::ST_RUN && stop_req && !blk_reset // RL10
        |=> !cpu_clk_en)
        else $error("cpu clock kept in stop");
    wake_start_a: assert property (state_q == bws_pkg::ST_STOP && ext_wake && !blk_reset // RL11
        |=> cnt_q == 8'h00 && state_q == bws_pkg::ST_STAB)
        else $error("wake did not start stabilization");
    cpu_run_a: assert property (cpu_clk_en // RL12
        |-> state_q == bws_pkg::ST_RUN)
        else $error("cpu clock released outside run");
    stab_pulse_a: assert property (stab_done // RL12
        |=> !stab_done)
        else $error("stabilization done longer than one cycle");
    stab_cause_a: assert property (stab_done // RL12
        |-> $past(stab_ovf))
        else $error("stabilization done without bit 3 overflow");
endmodule
`default_nettype wire

// >>> core/bws_pkg.sv
// Purpose: Shared constants and types for the basic watchdog and stabilizer timer.
// Assumes: Oscillator clock and CPU clock are the same 20 MHz clk.
// Notes: All register offsets and field positions live here.
package bws_pkg;
    // =====================================================================
    // Register map
    localparam logic [7:0] CTRL_ADDR = 8'hd3;
    localparam logic [7:0] CNT_ADDR = 8'hfd;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // =====================================================================
    // Control fields
    localparam int EN_MSB = 7;
    localparam int EN_LSB = 4;
    localparam logic [3:0] DISABLE_CODE = 4'ha;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 2;
    localparam int CNT_CLR_BIT = 1;
    localparam int DIV_CLR_BIT = 0;
    // =====================================================================
    // Prescaler
    localparam int PRESC_W = 14;
    localparam logic [1:0] SEL_4096 = 2'h0;
    localparam logic [1:0] SEL_1024 = 2'h1;
    localparam logic [1:0] SEL_128 = 2'h2;
    localparam logic [1:0] SEL_16384 = 2'h3;
    localparam logic [3:0] TAP_4096 = 4'hb;
    localparam logic [3:0] TAP_1024 = 4'h9;
    localparam logic [3:0] TAP_128 = 4'h6;
    localparam logic [3:0] TAP_16384 = 4'hd;
    // =====================================================================
    // Counter and stabilization
    localparam int CNT_W = 8;
    localparam int STAB_BIT = 3;
    localparam logic [3:0] STAB_LOW_MAX = 4'hf;
    localparam logic [7:0] CNT_MAX = 8'hff;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_STAB = 2'b10
    } bws_state_t;
endpackage

// >>> core/bws_prescaler.sv
// Purpose: Free-running oscillator divider with a selectable tick tap.
// Assumes: Runs on clk; frozen while the oscillator is stopped.
// Notes: A tick is a one-cycle enable at the selected divided rate.
`timescale 1ns/1ps
`default_nettype none
module bws_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    // Output
    output logic tick
);
    logic [bws_pkg::PRESC_W-1:0] div_q;
    logic [bws_pkg::PRESC_W-1:0] div_d;
    logic [bws_pkg::PRESC_W-1:0] mask;

    function automatic logic [3:0] tap_of(input logic [1:0] s);
        case (s)
            bws_pkg::SEL_4096: tap_of = bws_pkg::TAP_4096;
            bws_pkg::SEL_1024: tap_of = bws_pkg::TAP_1024;
            bws_pkg::SEL_128: tap_of = bws_pkg::TAP_128;
            default: tap_of = bws_pkg::TAP_16384;
        endcase
    endfunction

    // Each mask bit is set at or below the tap, so the tick fires once per wrap of the bits up to the tap.
    genvar g;
    generate
        for (g = 0; g < bws_pkg::PRESC_W; g++) begin : g_mask
            assign mask[g] = (4'(g) <= tap_of(sel));
        end
    endgenerate

    assign tick = run && !clear && ((div_q & mask) == mask); // RL3
    assign div_d = clear ? '0 : (run ? div_q + 1'b1 : div_q); // RL5

    always_ff @(posedge clk) begin
        if (reset) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end
endmodule
`default_nettype wire

// >>> bench/basic_watchdog_stabilizer_tb.sv
// Purpose: Self-checking bench for the basic watchdog and stabilizer timer.
// Assumes: Oscillator and CPU clock are both clk; inputs change by NBA at rising edges.
// Notes: Divide by 128 keeps long runs short; reset stabilization is sped up once its rate is seen.
`timescale 1ns/1ps
`default_nettype none
module basic_watchdog_stabilizer_tb;
    // ==========================================================================
    // Signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic stop_req = 1'b0;
    logic ext_wake = 1'b0;
    logic cpu_clk_en;
    logic stab_done;
    logic wdt_reset_req;
    logic gt_presc_clear;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    logic [7:0] rd;
    logic [3:0] nib;

    always #25 clk = ~clk;

    bws_top dut (
        .clk(clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .stop_req(stop_req),
        .ext_wake(ext_wake),
        .cpu_clk_en(cpu_clk_en),
        .stab_done(stab_done),
        .wdt_reset_req(wdt_reset_req),
        .gt_presc_clear(gt_presc_clear)
    );

    // ==========================================================================
    // Helpers
    function automatic logic near(input int got, input int exp, input int slack);
        return (got >= exp - slack) && (got <= exp + slack);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask

    // Counts cycles until the chosen output is high; sel 0 done, 1 watchdog, 2 divider clear.
    task automatic wait_hi(input int sel, input int lim, output int cnt);
        logic hit;
        cnt = 0;
        #1 hit = (sel == 0) ? stab_done : (sel == 1) ? wdt_reset_req : gt_presc_clear;
        while (hit !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            #1 cnt++;
            hit = (sel == 0) ? stab_done : (sel == 1) ? wdt_reset_req : gt_presc_clear;
        end
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 85000) begin
            errors++;
            final_report();
        end
    end

    // ==========================================================================
    // Main sequence
    initial begin
        n = $urandom(42017);
        nib = 4'($urandom % 15);
        if (nib >= 4'ha) begin
            nib = nib + 4'h1;
        end
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rdr(bws_pkg::CTRL_ADDR, rd);
        chk({8'h00, rd}, {8'h00, bws_pkg::CTRL_RESET});
        chk({15'h0000, cpu_clk_en}, 16'h0000);
        // The first tick after reset lands 4096 clocks after release.
        repeat (4085) @(posedge clk);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({8'h00, rd}, 16'h0000);
        repeat (8) @(posedge clk);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({8'h00, rd}, 16'h0001);
        // A faster rate finishes the remaining ticks of stabilization sooner.
        wr(bws_pkg::CTRL_ADDR, {nib, 4'h8});
        wait_hi(0, 2200, n);
        chk({15'h0000, near(n, 14 * 128 + 64, 72)}, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0000, cpu_clk_en}, 16'h0001);
        wr(bws_pkg::CTRL_ADDR, 8'ha8);
        rdr(bws_pkg::CTRL_ADDR, rd);
        chk({8'h00, rd}, 16'h00a8);
        // Disabled, a full wrap of the counter must pass with no reset request.
        wr(bws_pkg::CTRL_ADDR, 8'haa);
        wait_hi(1, 33000, n);
        chk({15'h0000, n == 33000}, 16'h0001);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({15'h0000, rd < 8'h04}, 16'h0001);
        chk({15'h0000, cpu_clk_en}, 16'h0001);
        wr(bws_pkg::CTRL_ADDR, {nib, 4'h7});
        repeat (1015) @(posedge clk);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({8'h00, rd}, 16'h0000);
        repeat (8) @(posedge clk);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({8'h00, rd}, 16'h0001);
        wr(bws_pkg::CTRL_ADDR, {nib, 4'hf});
        repeat (4200) @(posedge clk);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({8'h00, rd}, 16'h0000);
        wr(bws_pkg::CTRL_ADDR, {nib, 4'h8});
        rdr(bws_pkg::CTRL_ADDR, rd);
        chk({8'h00, rd}, {8'h00, nib, 4'h8});
        // The counter is read-only, so a write there must not land.
        wr(bws_pkg::CNT_ADDR, 8'h55);
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({15'h0000, rd == 8'h55}, 16'h0000);
        rdr(8'h00, rd);
        chk({8'h00, rd}, {8'h00, bws_pkg::UNMAPPED_READ});
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, cpu_clk_en}, 16'h0000);
        @(posedge clk);
        ext_wake <= 1'b1;
        @(posedge clk);
        ext_wake <= 1'b0;
        wait_hi(0, 2200, n);
        chk({15'h0000, near(n, 16 * 128 - 64, 72)}, 16'h0001);
        wr(bws_pkg::CTRL_ADDR, {nib, 4'hb});
        wait_hi(2, 4, n);
        chk({15'h0000, n <= 1}, 16'h0001);
        rdr(bws_pkg::CTRL_ADDR, rd);
        chk({8'h00, rd}, {8'h00, nib, 4'h8});
        rdr(bws_pkg::CNT_ADDR, rd);
        chk({8'h00, rd}, 16'h0000);
        wait_hi(1, 33000, n);
        chk({15'h0000, near(n, 256 * 128 - 12, 12)}, 16'h0001);
        rdr(bws_pkg::CTRL_ADDR, rd);
        chk({8'h00, rd}, 16'h0000);
        chk({15'h0000, cpu_clk_en}, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
